// ==== verilog/cpu8_cfg.svh ====
`ifndef CPU8_CFG_SVH
`define CPU8_CFG_SVH
// flag bit positions
`define CPU8_FLG_V 3'h7
`define CPU8_FLG_H 3'h4
`define CPU8_FLG_I 3'h3
`define CPU8_FLG_N 3'h2
`define CPU8_FLG_Z 3'h1
`define CPU8_FLG_C 3'h0
// reset values
`define CPU8_RST_PC 16'h0000
`define CPU8_RST_SP 16'h00ff
`define CPU8_RST_FLAGS 8'h08
`define CPU8_RST_BYTE 8'h00
`define CPU8_RST_WORD 16'h0000
// fixed values
`define CPU8_PAGE_ZERO 8'h00
`define CPU8_ZERO_BYTE 8'h00
`define CPU8_STEP 16'h0001
`define CPU8_LEN_NONE 2'h0
`define CPU8_LEN_BYTE 2'h1
`define CPU8_LEN_WORD 2'h2
// opcodes
`define CPU8_OP_PREFIX 8'h9e
`define CPU8_OP_ADC_IX2 8'hd9
`define CPU8_OP_ADD_IMM 8'hab
`define CPU8_OP_ADD_DIR 8'hbb
`define CPU8_OP_ADD_EXT 8'hcb
`define CPU8_OP_ADD_IX2 8'hdb
`define CPU8_OP_ADD_IX1 8'heb
`define CPU8_OP_ADD_IX 8'hfb
`define CPU8_OP_ADD_SP2 8'hdb
`define CPU8_OP_ADD_SP1 8'heb
`define CPU8_OP_AIS 8'ha7
`define CPU8_OP_AIX 8'haf
`define CPU8_OP_ASL_DIR 8'h38
`define CPU8_OP_ASL_A 8'h48
`define CPU8_OP_ASL_X 8'h58
`define CPU8_OP_ASL_IX1 8'h68
`define CPU8_OP_ASL_IX 8'h78
`define CPU8_OP_ASL_SP1 8'h68
`define CPU8_OP_ASR_DIR 8'h37
`define CPU8_OP_ASR_A 8'h47
`define CPU8_OP_ASR_X 8'h57
`define CPU8_OP_ASR_IX1 8'h67
`define CPU8_OP_ASR_IX 8'h77
`define CPU8_OP_ASR_SP1 8'h67
`define CPU8_OP_BCC 8'h24
`endif

// ==== verilog/cpu8_pkg.sv ====
package cpu8_pkg;

	typedef enum logic [10:0]
	{
		st_fetch_op = 11'h001,
		st_get_op = 11'h002,
		st_fetch_b1 = 11'h004,
		st_get_b1 = 11'h008,
		st_fetch_b2 = 11'h010,
		st_get_b2 = 11'h020,
		st_addr = 11'h040,
		st_fetch_m = 11'h080,
		st_get_m = 11'h100,
		st_exec = 11'h200,
		st_write = 11'h400
	} cpu8_state_type;

	typedef enum logic [2:0]
	{
		k_nop,
		k_add,
		k_adc,
		k_ais,
		k_aix,
		k_asl,
		k_asr,
		k_bcc
	} cpu8_kind_type;

	typedef enum logic [3:0]
	{
		no_operand_mode,
		literal_operand_mode,
		page_zero_mode,
		long_absolute_mode,
		pointer_plain_mode,
		pointer_plain_postinc_mode,
		pointer_short_offset_mode,
		pointer_short_postinc_mode,
		pointer_long_offset_mode,
		stack_short_offset_mode,
		stack_long_offset_mode,
		relative_mode
	} cpu8_mode_type;

	typedef struct packed
	{
		cpu8_kind_type kind;
		cpu8_mode_type mode;
		logic on_x;
	} cpu8_dec_type;

	typedef struct packed
	{
		logic [15:0] addr;
		logic [7:0] wdata;
		logic rd;
		logic wr;
	} cpu8_mem_req_type;

endpackage

// ==== verilog/cpu8_core.sv ====
`timescale 1ns/10ps
`include "cpu8_cfg.svh"

module cpu8_core
(
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// memory bus
	output cpu8_pkg::cpu8_mem_req_type mem_req_o,
	input wire logic [7:0] mem_rdata_i,
	// observed core state
	output logic [7:0] flags_register_o,
	output logic [7:0] acc_o,
	output logic [15:0] pointer_pair_o,
	output logic [15:0] stack_ptr_o,
	output logic [15:0] pc_o,
	output logic instr_done_o
);

	cpu8_pkg::cpu8_state_type state_q;
	cpu8_pkg::cpu8_state_type state_d;
	cpu8_pkg::cpu8_dec_type dec_q;
	cpu8_pkg::cpu8_dec_type dec_now;
	cpu8_pkg::cpu8_mem_req_type mem_req_q;
	cpu8_pkg::cpu8_mem_req_type mem_req_d;
	logic pre_q;
	logic [15:0] pc_q;
	logic [15:0] pc_d;
	logic [7:0] a_q;
	logic [15:0] hx_q;
	logic [15:0] sp_q;
	logic [7:0] flags_q;
	logic [7:0] op_hi_q;
	logic [7:0] op_lo_q;
	logic [7:0] m_q;
	logic [15:0] ea_q;
	logic [15:0] ea_c;
	logic done_q;
	logic [7:0] m_v;
	logic add_cin;
	logic [8:0] add_sum;
	logic [4:0] add_nib;
	logic add_v;
	logic [7:0] sh_v;
	logic [7:0] sh_r;
	logic sh_c;
	logic in_exec;
	logic is_add;
	logic is_shift;
	logic is_prefix;

	function automatic cpu8_pkg::cpu8_dec_type decode
	(
		input logic pre,
		input logic [7:0] opc
	);
		cpu8_pkg::cpu8_dec_type d;
		d.kind = cpu8_pkg::k_nop;
		d.mode = cpu8_pkg::no_operand_mode;
		d.on_x = 1'b0;
		// unknown opcodes fall through as a no-op rather than trap
		if (!pre)
		begin
			case (opc)
				`CPU8_OP_ADC_IX2:
				begin
					d.kind = cpu8_pkg::k_adc;
					d.mode = cpu8_pkg::pointer_long_offset_mode;
				end
				`CPU8_OP_ADD_IMM:
				begin
					d.kind = cpu8_pkg::k_add;
					d.mode = cpu8_pkg::literal_operand_mode;
				end
				`CPU8_OP_ADD_DIR:
				begin
					d.kind = cpu8_pkg::k_add;
					d.mode = cpu8_pkg::page_zero_mode;
				end
				`CPU8_OP_ADD_EXT:
				begin
					d.kind = cpu8_pkg::k_add;
					d.mode = cpu8_pkg::long_absolute_mode;
				end
				`CPU8_OP_ADD_IX2:
				begin
					d.kind = cpu8_pkg::k_add;
					d.mode = cpu8_pkg::pointer_long_offset_mode;
				end
				`CPU8_OP_ADD_IX1:
				begin
					d.kind = cpu8_pkg::k_add;
					d.mode = cpu8_pkg::pointer_short_offset_mode;
				end
				`CPU8_OP_ADD_IX:
				begin
					d.kind = cpu8_pkg::k_add;
					d.mode = cpu8_pkg::pointer_plain_mode;
				end
				`CPU8_OP_AIS:
				begin
					d.kind = cpu8_pkg::k_ais;
					d.mode = cpu8_pkg::literal_operand_mode;
				end
				`CPU8_OP_AIX:
				begin
					d.kind = cpu8_pkg::k_aix;
					d.mode = cpu8_pkg::literal_operand_mode;
				end
				`CPU8_OP_ASL_DIR, `CPU8_OP_ASR_DIR:
				begin
					d.mode = cpu8_pkg::page_zero_mode;
				end
				`CPU8_OP_ASL_A, `CPU8_OP_ASR_A:
				begin
					d.mode = cpu8_pkg::no_operand_mode;
				end
				`CPU8_OP_ASL_X, `CPU8_OP_ASR_X:
				begin
					d.mode = cpu8_pkg::no_operand_mode;
					d.on_x = 1'b1;
				end
				`CPU8_OP_ASL_IX1, `CPU8_OP_ASR_IX1:
				begin
					d.mode = cpu8_pkg::pointer_short_offset_mode;
				end
				`CPU8_OP_ASL_IX, `CPU8_OP_ASR_IX:
				begin
					d.mode = cpu8_pkg::pointer_plain_mode;
				end
				`CPU8_OP_BCC:
				begin
					d.kind = cpu8_pkg::k_bcc;
					d.mode = cpu8_pkg::relative_mode;
				end
				default:
				begin
					d.kind = cpu8_pkg::k_nop;
				end
			endcase
		end
		else
		begin
			case (opc)
				`CPU8_OP_ADD_SP2:
				begin
					d.kind = cpu8_pkg::k_add;
					d.mode = cpu8_pkg::stack_long_offset_mode;
				end
				`CPU8_OP_ADD_SP1:
				begin
					d.kind = cpu8_pkg::k_add;
					d.mode = cpu8_pkg::stack_short_offset_mode;
				end
				`CPU8_OP_ASL_SP1, `CPU8_OP_ASR_SP1:
				begin
					d.mode = cpu8_pkg::stack_short_offset_mode;
				end
				default:
				begin
					d.kind = cpu8_pkg::k_nop;
				end
			endcase
		end
		// shift direction sits in the low opcode nibble; other prefixed
		// codes in that range must stay no-ops, only the stack form shifts
		if (d.kind == cpu8_pkg::k_nop && (opc[3:0] == 4'h8 || opc[3:0] == 4'h7)
			&& (opc[7:4] <= 4'h7 && opc[7:4] >= 4'h3)
			&& (!pre || opc[7:4] == 4'h6))
		begin
			d.kind = opc[3] ? cpu8_pkg::k_asl : cpu8_pkg::k_asr;
		end
		// post-increment forms belong to compare/copy, not decoded here
		return d;
	endfunction

	function automatic logic [1:0] op_len(input cpu8_pkg::cpu8_mode_type m);
		case (m)
			cpu8_pkg::long_absolute_mode,
			cpu8_pkg::pointer_long_offset_mode,
			cpu8_pkg::stack_long_offset_mode: op_len = `CPU8_LEN_WORD;
			cpu8_pkg::literal_operand_mode,
			cpu8_pkg::page_zero_mode,
			cpu8_pkg::pointer_short_offset_mode,
			cpu8_pkg::pointer_short_postinc_mode,
			cpu8_pkg::stack_short_offset_mode,
			cpu8_pkg::relative_mode: op_len = `CPU8_LEN_BYTE;
			default: op_len = `CPU8_LEN_NONE;
		endcase
	endfunction

	function automatic logic needs_mem(input cpu8_pkg::cpu8_mode_type m);
		needs_mem = !(m == cpu8_pkg::no_operand_mode
			|| m == cpu8_pkg::literal_operand_mode
			|| m == cpu8_pkg::relative_mode);
	endfunction

	assign dec_now = decode(pre_q, mem_rdata_i);
	assign is_prefix = (mem_rdata_i == `CPU8_OP_PREFIX) && !pre_q;
	assign in_exec = (state_q == cpu8_pkg::st_exec);
	assign is_add = (dec_q.kind == cpu8_pkg::k_add)
		|| (dec_q.kind == cpu8_pkg::k_adc);
	assign is_shift = (dec_q.kind == cpu8_pkg::k_asl)
		|| (dec_q.kind == cpu8_pkg::k_asr);

	// effective address
	always_comb
	begin
		case (dec_q.mode)
			cpu8_pkg::page_zero_mode: ea_c = {`CPU8_PAGE_ZERO, op_lo_q};
			cpu8_pkg::long_absolute_mode: ea_c = {op_hi_q, op_lo_q};
			cpu8_pkg::pointer_short_offset_mode,
			cpu8_pkg::pointer_short_postinc_mode:
				ea_c = hx_q + {`CPU8_PAGE_ZERO, op_lo_q};
			cpu8_pkg::pointer_long_offset_mode:
				ea_c = hx_q + {op_hi_q, op_lo_q};
			cpu8_pkg::stack_short_offset_mode:
				ea_c = sp_q + {`CPU8_PAGE_ZERO, op_lo_q};
			cpu8_pkg::stack_long_offset_mode:
				ea_c = sp_q + {op_hi_q, op_lo_q};
			default: ea_c = hx_q;
		endcase
	end

	// arithmetic
	always_comb
	begin
		m_v = (dec_q.mode == cpu8_pkg::literal_operand_mode) ? op_lo_q : m_q;
		add_cin = (dec_q.kind == cpu8_pkg::k_adc) & flags_q[`CPU8_FLG_C];
		add_sum = {1'b0, a_q} + {1'b0, m_v} + {8'h00, add_cin};
		add_nib = {1'b0, a_q[3:0]} + {1'b0, m_v[3:0]} + {4'h0, add_cin};
		add_v = (a_q[7] & m_v[7] & ~add_sum[7])
			| (~a_q[7] & ~m_v[7] & add_sum[7]);
		if (dec_q.mode == cpu8_pkg::no_operand_mode)
			sh_v = dec_q.on_x ? hx_q[7:0] : a_q;
		else
			sh_v = m_q;
		if (dec_q.kind == cpu8_pkg::k_asl)
		begin
			sh_r = {sh_v[6:0], 1'b0};
			sh_c = sh_v[7];
		end
		else
		begin
			sh_r = {sh_v[7], sh_v[7:1]};
			sh_c = sh_v[0];
		end
	end

	// sequencing
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			cpu8_pkg::st_fetch_op: state_d = cpu8_pkg::st_get_op;
			cpu8_pkg::st_get_op:
				if (is_prefix)
					state_d = cpu8_pkg::st_fetch_op;
				else if (op_len(dec_now.mode) != `CPU8_LEN_NONE)
					state_d = cpu8_pkg::st_fetch_b1;
				else if (needs_mem(dec_now.mode))
					state_d = cpu8_pkg::st_addr;
				else
					state_d = cpu8_pkg::st_exec;
			cpu8_pkg::st_fetch_b1: state_d = cpu8_pkg::st_get_b1;
			cpu8_pkg::st_get_b1:
				if (op_len(dec_q.mode) == `CPU8_LEN_WORD)
					state_d = cpu8_pkg::st_fetch_b2;
				else if (needs_mem(dec_q.mode))
					state_d = cpu8_pkg::st_addr;
				else
					state_d = cpu8_pkg::st_exec;
			cpu8_pkg::st_fetch_b2: state_d = cpu8_pkg::st_get_b2;
			cpu8_pkg::st_get_b2:
				state_d = needs_mem(dec_q.mode) ? cpu8_pkg::st_addr
					: cpu8_pkg::st_exec;
			cpu8_pkg::st_addr: state_d = cpu8_pkg::st_fetch_m;
			cpu8_pkg::st_fetch_m: state_d = cpu8_pkg::st_get_m;
			cpu8_pkg::st_get_m: state_d = cpu8_pkg::st_exec;
			cpu8_pkg::st_exec:
				state_d = (is_shift && needs_mem(dec_q.mode))
					? cpu8_pkg::st_write : cpu8_pkg::st_fetch_op;
			cpu8_pkg::st_write: state_d = cpu8_pkg::st_fetch_op;
			default: state_d = cpu8_pkg::st_fetch_op;
		endcase
	end

	// program counter; it already points past the branch's last byte
	always_comb
	begin
		pc_d = pc_q;
		if (state_q == cpu8_pkg::st_get_op || state_q == cpu8_pkg::st_get_b1
			|| state_q == cpu8_pkg::st_get_b2)
			pc_d = pc_q + `CPU8_STEP;
		else if (in_exec && dec_q.kind == cpu8_pkg::k_bcc
			&& !flags_q[`CPU8_FLG_C])
			pc_d = pc_q + {{8{op_lo_q[7]}}, op_lo_q};
	end

	// bus request is issued one state ahead so the port is a flop
	always_comb
	begin
		mem_req_d = '0;
		case (state_d)
			cpu8_pkg::st_fetch_op,
			cpu8_pkg::st_fetch_b1,
			cpu8_pkg::st_fetch_b2:
			begin
				mem_req_d.addr = pc_d;
				mem_req_d.rd = 1'b1;
			end
			cpu8_pkg::st_fetch_m:
			begin
				mem_req_d.addr = ea_c;
				mem_req_d.rd = 1'b1;
			end
			cpu8_pkg::st_write:
			begin
				mem_req_d.addr = ea_q;
				mem_req_d.wdata = sh_r;
				mem_req_d.wr = 1'b1;
			end
			default: mem_req_d = '0;
		endcase
	end

	// reset lands in execute of a no-op, which then starts the fetch
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			state_q <= cpu8_pkg::st_exec;
			mem_req_q <= '0;
			pc_q <= `CPU8_RST_PC;
			done_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			mem_req_q <= mem_req_d;
			pc_q <= pc_d;
			done_q <= in_exec;
		end
	end

	// instruction and operand capture
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			pre_q <= 1'b0;
			dec_q <= '{kind: cpu8_pkg::k_nop, mode: cpu8_pkg::no_operand_mode,
				on_x: 1'b0};
			op_hi_q <= `CPU8_RST_BYTE;
			op_lo_q <= `CPU8_RST_BYTE;
			m_q <= `CPU8_RST_BYTE;
			ea_q <= `CPU8_RST_WORD;
		end
		else
		begin
			if (state_q == cpu8_pkg::st_get_op)
			begin
				pre_q <= is_prefix;
				if (!is_prefix)
					dec_q <= dec_now;
			end
			if (state_q == cpu8_pkg::st_get_b1)
			begin
				if (op_len(dec_q.mode) == `CPU8_LEN_WORD)
					op_hi_q <= mem_rdata_i;
				else
					op_lo_q <= mem_rdata_i;
			end
			if (state_q == cpu8_pkg::st_get_b2)
				op_lo_q <= mem_rdata_i;
			if (state_q == cpu8_pkg::st_addr)
				ea_q <= ea_c;
			if (state_q == cpu8_pkg::st_get_m)
				m_q <= mem_rdata_i;
		end
	end

	// accumulator
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			a_q <= `CPU8_RST_BYTE;
		else if (in_exec && is_add)
			a_q <= add_sum[7:0];
		else if (in_exec && is_shift && !dec_q.on_x
			&& dec_q.mode == cpu8_pkg::no_operand_mode)
			a_q <= sh_r;
	end

	// index pair
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			hx_q <= `CPU8_RST_WORD;
		else if (in_exec && dec_q.kind == cpu8_pkg::k_aix)
			hx_q <= hx_q + {{8{op_lo_q[7]}}, op_lo_q};
		else if (in_exec && is_shift && dec_q.on_x)
			hx_q <= {hx_q[15:8], sh_r};
		else if (in_exec && (dec_q.mode == cpu8_pkg::pointer_plain_postinc_mode
			|| dec_q.mode == cpu8_pkg::pointer_short_postinc_mode))
			hx_q <= hx_q + `CPU8_STEP;
	end

	// stack pointer
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			sp_q <= `CPU8_RST_SP;
		else if (in_exec && dec_q.kind == cpu8_pkg::k_ais)
			sp_q <= sp_q + {{8{op_lo_q[7]}}, op_lo_q};
	end

	// flags; the mask bit is never touched by these instructions
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			flags_q <= `CPU8_RST_FLAGS;
		else if (in_exec && is_add)
		begin
			flags_q[`CPU8_FLG_V] <= add_v;
			flags_q[`CPU8_FLG_H] <= add_nib[4];
			flags_q[`CPU8_FLG_N] <= add_sum[7];
			flags_q[`CPU8_FLG_Z] <= (add_sum[7:0] == `CPU8_ZERO_BYTE);
			flags_q[`CPU8_FLG_C] <= add_sum[8];
		end
		else if (in_exec && is_shift)
		begin
			flags_q[`CPU8_FLG_V] <= sh_r[7] ^ sh_c;
			flags_q[`CPU8_FLG_N] <= sh_r[7];
			flags_q[`CPU8_FLG_Z] <= (sh_r == `CPU8_ZERO_BYTE);
			flags_q[`CPU8_FLG_C] <= sh_c;
		end
	end

	assign mem_req_o = mem_req_q;
	assign flags_register_o = flags_q;
	assign acc_o = a_q;
	assign pointer_pair_o = hx_q;
	assign stack_ptr_o = sp_q;
	assign pc_o = pc_q;
	assign instr_done_o = done_q;

	a_mask_kept: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$stable(flags_q[`CPU8_FLG_I]))
		else $error("interrupt mask changed");

	a_add_result: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		in_exec && is_add |=> {flags_q[`CPU8_FLG_C], a_q}
			== {1'b0, $past(a_q)} + {1'b0, $past(m_v)} + {8'h00, $past(add_cin)})
		else $error("add result or carry wrong");

	a_page_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		state_q == cpu8_pkg::st_fetch_m && dec_q.mode == cpu8_pkg::page_zero_mode
		|-> mem_req_q.addr == {`CPU8_PAGE_ZERO, op_lo_q} && mem_req_q.rd)
		else $error("page zero address wrong");

	a_ext_order: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		state_q == cpu8_pkg::st_fetch_m
		&& dec_q.mode == cpu8_pkg::long_absolute_mode
		|-> mem_req_q.addr == {op_hi_q, op_lo_q})
		else $error("word operand order wrong");

	a_branch_target: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		in_exec && dec_q.kind == cpu8_pkg::k_bcc
		|=> pc_q == ($past(flags_q[`CPU8_FLG_C]) ? $past(pc_q)
			: $past(pc_q) + {{8{$past(op_lo_q[7])}}, $past(op_lo_q)})
			&& $stable(flags_q))
		else $error("branch target or flags wrong");

	a_stack_bump: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		in_exec && dec_q.kind == cpu8_pkg::k_ais
		|=> sp_q == $past(sp_q) + {{8{$past(op_lo_q[7])}}, $past(op_lo_q)}
			&& $stable(flags_q))
		else $error("stack bump wrong");

	a_pointer_bump: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		in_exec && dec_q.kind == cpu8_pkg::k_aix
		|=> hx_q == $past(hx_q) + {{8{$past(op_lo_q[7])}}, $past(op_lo_q)}
			&& $stable(flags_q))
		else $error("pointer bump wrong");

	a_shift_left: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		in_exec && dec_q.kind == cpu8_pkg::k_asl && !dec_q.on_x
		&& dec_q.mode == cpu8_pkg::no_operand_mode
		|=> a_q == {$past(a_q[6:0]), 1'b0}
			&& flags_q[`CPU8_FLG_C] == $past(a_q[7]))
		else $error("shift left wrong");

	a_shift_ovf: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		in_exec && is_shift
		|=> flags_q[`CPU8_FLG_V] == (flags_q[`CPU8_FLG_N] ^ flags_q[`CPU8_FLG_C])
			&& $stable(flags_q[`CPU8_FLG_H]))
		else $error("shift flags wrong");

	a_shift_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		in_exec && is_shift && needs_mem(dec_q.mode)
		|=> mem_req_q.wr && mem_req_q.addr == $past(ea_q) ##1 !mem_req_q.wr)
		else $error("shift write-back missing");

endmodule

// ==== dv/cpu8_mem_model.sv ====
`timescale 1ns/10ps
// byte memory answering one cycle after each read; it never stalls
module cpu8_mem_model
(
	// clock
	input wire logic clk_i,
	// bus from the core
	input wire cpu8_pkg::cpu8_mem_req_type mem_req_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:65535];
	initial rdata_o = 8'h5a;
	// outside the answer cycle the data toggles so stale bytes never match
	always @(posedge clk_i)
	begin
		if (mem_req_i.rd)
			rdata_o <= mem[mem_req_i.addr];
		else
			rdata_o <= ~rdata_o;
		if (mem_req_i.wr)
			mem[mem_req_i.addr] <= mem_req_i.wdata;
	end
endmodule

// ==== dv/cpu8_opcode_decode_execute_test.sv ====
`timescale 1ns/10ps
module cpu8_opcode_decode_execute_test;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	cpu8_pkg::cpu8_mem_req_type mem_req;
	logic [7:0] rdata;
	logic [7:0] flags;
	logic [7:0] acc;
	logic [15:0] hx;
	logic [15:0] sp;
	logic [15:0] pc;
	logic done;
	int mismatches = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [7:0] ref_mem [0:65535];
	logic [7:0] ra;
	logic [7:0] rf;
	logic [15:0] rhx;
	logic [15:0] rsp;
	logic [15:0] rpc;
	logic [15:0] wa;
	logic wv = 1'b0;
	// operand byte count, prefix flag, opcode
	logic [15:0] ops [0:23] = '{16'h10ab, 16'h10bb, 16'h20cb, 16'h20db,
		16'h10eb, 16'h00fb, 16'h21db, 16'h11eb, 16'h20d9, 16'h10a7,
		16'h10af, 16'h1038, 16'h0048, 16'h0058, 16'h1068, 16'h0078,
		16'h1168, 16'h1037, 16'h0047, 16'h0057, 16'h1067, 16'h0077,
		16'h1167, 16'h1024};

	always #25 clk_i = ~clk_i;

	// ceiling is about three times the longest expected run
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			tally_and_finish();
		end
	end

	cpu8_core cpu8_core_i
	(
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.mem_req_o(mem_req),
		.mem_rdata_i(rdata),
		.flags_register_o(flags),
		.acc_o(acc),
		.pointer_pair_o(hx),
		.stack_ptr_o(sp),
		.pc_o(pc),
		.instr_done_o(done)
	);

	cpu8_mem_model cpu8_mem_model_i
	(
		.clk_i(clk_i),
		.mem_req_i(mem_req),
		.rdata_o(rdata)
	);

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t %s seen %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (mismatches == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function automatic logic [15:0] add8(input logic [7:0] a,
		input logic [7:0] m, input logic c, input logic [7:0] f);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, a} + {1'b0, m} + {8'h00, c};
		h = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, c};
		f[7] = (a[7] == m[7]) && (s[7] != a[7]);
		f[4] = h[4];
		f[2] = s[7];
		f[1] = s[7:0] == 8'h00;
		f[0] = s[8];
		return {f, s[7:0]};
	endfunction

	function automatic logic [15:0] shift8(input logic [7:0] v,
		input logic left, input logic [7:0] f);
		logic [7:0] r;
		r = left ? {v[6:0], 1'b0} : {v[7], v[7:1]};
		f[0] = left ? v[7] : v[0];
		f[2] = r[7];
		f[1] = r == 8'h00;
		f[7] = r[7] ^ f[0];
		return {f, r};
	endfunction

	// reference step of one instruction; unknown codes are no-ops
	task automatic step();
		logic [7:0] op;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] m;
		logic [15:0] ea;
		logic [15:0] base;
		logic [15:0] fr;
		logic [15:0] jmp;
		logic [15:0] n;
		logic pre;
		pre = ref_mem[rpc] == 8'h9e;
		ea = rpc + {15'h0000, pre};
		op = ref_mem[ea];
		b1 = ref_mem[ea + 16'h0001];
		b2 = ref_mem[ea + 16'h0002];
		base = pre ? rsp : rhx;
		n = 16'h0001;
		jmp = 16'h0000;
		ea = rhx;
		if (!pre && (op == 8'ha7 || op == 8'haf))
		begin
			n = 16'h0002;
			if (op[3])
				rhx = rhx + {{8{b1[7]}}, b1};
			else
				rsp = rsp + {{8{b1[7]}}, b1};
		end
		else if (!pre && op == 8'h24)
		begin
			n = 16'h0002;
			if (!rf[0])
				jmp = {{8{b1[7]}}, b1};
		end
		else if ((op[3:0] == 4'hb && op[7:4] >= 4'ha &&
			(!pre || op[7:4] == 4'hd || op[7:4] == 4'he)) ||
			(op == 8'hd9 && !pre))
		begin
			case (op[7:4])
				4'hb: ea = {8'h00, b1};
				4'hc: ea = {b1, b2};
				4'hd: ea = base + {b1, b2};
				4'he: ea = base + {8'h00, b1};
				default: ;
			endcase
			n = (op[7:4] == 4'hc || op[7:4] == 4'hd) ? 16'h0003 :
				(op[7:4] == 4'hf ? 16'h0001 : 16'h0002);
			m = op[7:4] == 4'ha ? b1 : ref_mem[ea];
			fr = add8(ra, m, !op[1] && rf[0], rf);
			ra = fr[7:0];
			rf = fr[15:8];
		end
		else if ((op[3:0] == 4'h8 || op[3:0] == 4'h7) && op[7:4] >= 4'h3 &&
			op[7:4] <= 4'h7 && (!pre || op[7:4] == 4'h6))
		begin
			if (op[7:4] == 4'h3)
				ea = {8'h00, b1};
			if (op[7:4] == 4'h6)
				ea = base + {8'h00, b1};
			n = (op[7:4] == 4'h3 || op[7:4] == 4'h6) ? 16'h0002 : 16'h0001;
			m = op[7:4] == 4'h4 ? ra :
				(op[7:4] == 4'h5 ? rhx[7:0] : ref_mem[ea]);
			fr = shift8(m, op[3], rf);
			rf = fr[15:8];
			if (op[7:4] == 4'h4)
				ra = fr[7:0];
			else if (op[7:4] == 4'h5)
				rhx[7:0] = fr[7:0];
			else
			begin
				ref_mem[ea] = fr[7:0];
				wa = ea;
				wv = 1'b1;
			end
		end
		rpc = rpc + n + {15'h0000, pre} + jmp;
	endtask

	task automatic wait_done();
		int k;
		k = 0;
		do
		begin
			@(negedge clk_i);
			k++;
		end
		while (done !== 1'b1 && k < 40);
		if (done !== 1'b1)
			check("done", 16'h0000, 16'h0001);
	endtask

	// a shift write lands one edge after the pulse, so it is checked at
	// the following pulse, before the reference steps again
	task automatic compare();
		wait_done();
		if (wv)
			check("mem", {8'h00, cpu8_mem_model_i.mem[wa]},
				{8'h00, ref_mem[wa]});
		wv = 1'b0;
		step();
		check("pc", pc, rpc);
		check("acc", {8'h00, acc}, {8'h00, ra});
		check("flags", {8'h00, flags}, {8'h00, rf});
		check("hx", hx, rhx);
		check("sp", sp, rsp);
	endtask

	// called right after a pulse; a pending shift write lands on the first edge, before reset rises
	task automatic do_reset();
		@(posedge clk_i);
		#5 sys_rst_i = 1'b1;
		repeat (6) @(posedge clk_i);
		check("rst flags", {8'h00, flags}, 16'h0008);
		check("rst sp", sp, 16'h00ff);
		check("rst pc", pc, 16'h0000);
		check("rst hx", hx, 16'h0000);
		check("rst acc", {8'h00, acc}, 16'h0000);
		check("rst done", {15'h0000, done}, 16'h0000);
		#5 sys_rst_i = 1'b0;
		ra = 8'h00;
		rf = 8'h08;
		rhx = 16'h0000;
		rsp = 16'h00ff;
		rpc = 16'h0000;
		wait_done();
	endtask

	initial
	begin
		int p;
		int k;
		logic [15:0] e;
		logic [7:0] hand [0:16];
		p = $urandom(58);
		for (k = 0; k < 65536; k++)
			ref_mem[k] = 8'($urandom);
		// code everywhere, so branches always land in live instructions
		p = 17;
		while (p < 65530)
		begin
			e = ops[$urandom_range(23)];
			if (e[8])
			begin
				ref_mem[p] = 8'h9e;
				p++;
			end
			ref_mem[p] = e[7:0];
			p = p + 1 + int'(e[15:12]);
		end
		// sp -128, hx wrap, carry and overflow, offset wrap, branch by 0
		hand = '{8'ha7, 8'h80, 8'haf, 8'hff, 8'hab, 8'h88, 8'hab, 8'h88,
			8'hd9, 8'h00, 8'h02, 8'h24, 8'h00, 8'h58, 8'h9e, 8'h68, 8'hff};
		for (k = 0; k < 17; k++)
			ref_mem[k] = hand[k];
		for (k = 0; k < 65536; k++)
			cpu8_mem_model_i.mem[k] = ref_mem[k];
		do_reset();
		repeat (300) compare();
		do_reset();
		repeat (300) compare();
		@(negedge clk_i);
		if (wv)
			check("last mem", {8'h00, cpu8_mem_model_i.mem[wa]},
				{8'h00, ref_mem[wa]});
		tally_and_finish();
	end
endmodule
